// ===== dv/core_tunnel_model.sv
// Tunnel packet source standing in for the central MAC core
`timescale 1ns/1ps
`default_nettype none
module core_tunnel_model
(
  input  wire logic       clk,
  input  wire logic       tun_ready,
  input  wire logic [7:0] own_tag,
  output logic            tun_valid,
  output logic      [7:0] tun_data,
  output logic            tun_sop,
  output logic            tun_eop
);
  // ==========================================================
  // Idle lines at time zero
  initial
  begin
    tun_valid = 1'b0;
    tun_data  = 8'h00;
    tun_sop   = 1'b0;
    tun_eop   = 1'b0;
  end

  // ==========================================================
  // One tunnel packet, held per byte until taken; counts stalls
  task automatic send(input logic [31:0] sess, input logic [15:0] seq,
                      input logic [7:0] flow, input int npk,
                      input logic [12:0] base, input logic mc,
                      input logic [15:0] foreign, output int lows);
    logic [7:0]  q[$];
    logic [12:0] pid;
    int          k;
    lows = 0;
    // Session, flow, reserved, sequence, all MSB first
    q = {sess[31:24], sess[23:16], sess[15:8], sess[7:0],
         flow, 8'h00, seq[15:8], seq[7:0]};
    for (k = 0; k < npk; k++)
    begin
      pid = base + 13'(k);
      if (mc)
        q.push_back(foreign[k] ? ~own_tag : own_tag);
      q.push_back(vcond_pkg::TS_SYNC);
      q.push_back({3'h0, pid[12:8]});
      q.push_back(pid[7:0]);
      q.push_back(8'h10); // Payload only, no PCR
      repeat (184) q.push_back(pid[7:0]);
    end
    foreach (q[i])
    begin
      @(negedge clk);
      tun_valid = 1'b1;
      tun_data  = q[i];
      tun_sop   = (i == 0);
      tun_eop   = (i == q.size() - 1);
      @(posedge clk);
      while (tun_ready !== 1'b1)
      begin
        lows++;
        @(posedge clk);
      end
    end
    // Released bus shows the inverse, not a stale byte
    @(negedge clk);
    tun_valid = 1'b0;
    tun_data  = ~tun_data;
    tun_sop   = 1'b0;
    tun_eop   = 1'b0;
  endtask : send
endmodule : core_tunnel_model
`default_nettype wire

// ===== dv/video_stream_conditioner_tb.sv
// Self-checking bench for the video stream conditioner
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, gt) \
  begin \
    comparisons++; \
    if ((gt) !== (ex)) \
    begin \
      bad_count++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module video_stream_conditioner_tb;
  logic        clk, rst, sync_mode, mc_mode, tun_valid, tun_sop, tun_eop;
  logic        tun_ready, ts_valid, ts_sop, have_cc;
  logic [31:0] session;
  logic [7:0]  tag, tun_data, ts_data, b3, b4;
  logic [15:0] interval;
  logic [32:0] pcr_step;
  logic [12:0] pid, pid_q[$];
  logic [7:0]  b4_q[$];
  logic [3:0]  last_cc;
  int          bad_count, comparisons, cyc, cnt, last_sop, lows;
  localparam logic [12:0] NP = vcond_pkg::NULL_PID;

  // ==========================================================
  // Clock and fixed configuration
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  video_stream_conditioner u_dut
  (
    .CORE_CLK                  (clk),
    .RST                       (rst),
    .SYNC_MODE                 (sync_mode),
    .MULTI_CHANNEL_STREAM_MODE (mc_mode),
    .SESSION_ID                (session),
    .CHANNEL_TAG               (tag),
    .PKT_INTERVAL              (interval),
    .PCR_BASE_STEP             (pcr_step),
    .TUN_VALID                 (tun_valid),
    .TUN_DATA                  (tun_data),
    .TUN_SOP                   (tun_sop),
    .TUN_EOP                   (tun_eop),
    .TUN_READY                 (tun_ready),
    .TS_VALID                  (ts_valid),
    .TS_DATA                   (ts_data),
    .TS_SOP                    (ts_sop)
  );

  core_tunnel_model u_core
  (
    .clk       (clk),
    .tun_ready (tun_ready),
    .own_tag   (tag),
    .tun_valid (tun_valid),
    .tun_data  (tun_data),
    .tun_sop   (tun_sop),
    .tun_eop   (tun_eop)
  );

  // ==========================================================
  // Output monitor: framing, pacing, null headers, packet log
  always @(posedge clk)
  begin
    cyc++;
    if (rst)
    begin
      cnt = 0;
      last_sop = 0;
      have_cc = 1'b0;
    end
    else
    begin
      if (ts_sop === 1'b1)
      begin
        `CHECK("ts_sync", vcond_pkg::TS_SYNC, ts_data)
        if (last_sop != 0)
          `CHECK("slot_gap", int'(interval), cyc - last_sop)
        last_sop = cyc;
        cnt = 0;
      end
      if (ts_valid === 1'b1)
      begin
        if (cnt == 1) pid[12:8] = ts_data[4:0];
        if (cnt == 2) pid[7:0] = ts_data;
        if (cnt == 3) b3 = ts_data;
        if (cnt == 4) b4 = ts_data;
        cnt++;
      end
      else if (cnt > 0)
      begin
        `CHECK("ts_len", 188, cnt)
        if (pid === NP)
        begin
          `CHECK("null_hdr", vcond_pkg::NULL_HDR3[7:4], b3[7:4])
          if (have_cc)
            `CHECK("null_cc", last_cc + 4'h1, b3[3:0])
          have_cc = 1'b1;
          last_cc = b3[3:0];
        end
        pid_q.push_back(pid);
        b4_q.push_back(b4);
        cnt = 0;
      end
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic t_reset(input logic sm, input logic mc);
    @(negedge clk);
    rst = 1'b1;
    sync_mode = sm;
    mc_mode = mc;
    repeat (5) @(negedge clk);
    `CHECK("ready_rst", 1'b0, tun_ready)
    `CHECK("valid_rst", 1'b0, ts_valid)
    pid_q.delete();
    b4_q.delete();
    rst = 1'b0;
  endtask : t_reset

  // Finds first data packet, then compares the packet order
  task automatic check_seq(input logic [12:0] ex[$]);
    int i, g;
    i = 0;
    g = 0;
    while (g < 40000 && (pid_q.size() <= i || pid_q[i] === NP))
      if (pid_q.size() > i) i++;
      else
      begin
        @(posedge clk);
        g++;
      end
    foreach (ex[j])
    begin
      while (pid_q.size() <= i + j && g < 40000)
      begin
        @(posedge clk);
        g++;
      end
      `CHECK("pid", ex[j], pid_q[i + j])
      `CHECK("body", (ex[j] === NP) ? vcond_pkg::STUFF_BYTE : ex[j][7:0],
             b4_q[i + j])
    end
  endtask : check_seq

  task automatic give_verdict;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Scenarios
  task automatic t_idle_null;
    int g;
    for (g = 0; g < 2000 && pid_q.size() < 2; g++) @(posedge clk);
    `CHECK("idle_pid", NP, pid_q[0])
    `CHECK("idle_fill", vcond_pkg::STUFF_BYTE, b4_q[0])
  endtask : t_idle_null

  // Sync mode: single loss refilled in place, double loss resyncs
  task automatic t_loss;
    u_core.send(session, 16'h0005, 8'h00, 3, 13'h100, 1'b0, 16'h0, lows);
    `CHECK("first_stall", 0, lows)
    u_core.send(session, 16'h0007, 8'h00, 2, 13'h103, 1'b0, 16'h0, lows);
    `CHECK("refill_stall", 3, lows)
    u_core.send(~session, 16'h0008, 8'h00, 1, 13'h150, 1'b0, 16'h0, lows);
    `CHECK("foreign_stall", 0, lows)
    u_core.send(session, 16'h000A, 8'h00, 1, 13'h105, 1'b0, 16'h0, lows);
    `CHECK("gap2_stall", 0, lows)
    check_seq({13'h100, 13'h101, 13'h102, NP, NP, NP,
               13'h103, 13'h104, 13'h105, NP});
  endtask : t_loss

  // Async multi-channel: foreign tag and eleventh packet dropped
  task automatic t_max;
    t_reset(1'b0, 1'b1);
    u_core.send(session, 16'h0000, 8'h5A, 11, 13'h200, 1'b1, 16'h0002, lows);
    `CHECK("max_stall", 0, lows)
    check_seq({13'h200, 13'h202, 13'h203, 13'h204, 13'h205, 13'h206,
               13'h207, 13'h208, 13'h209, NP});
  endtask : t_max

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    bad_count = 0;
    comparisons = 0;
    cyc = 0;
    cnt = 0;
    rst = 1'b1;
    sync_mode = 1'b1;
    mc_mode = 1'b0;
    session = 32'hC0DE0001;
    tag = 8'h21;
    interval = 16'h00C8;
    pcr_step = 33'h000000002;
    t_reset(1'b1, 1'b0);
    t_idle_null;
    t_loss;
    t_max;
    give_verdict;
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    bad_count++;
    give_verdict;
  end
endmodule : video_stream_conditioner_tb
`default_nettype wire

// ===== hw/ts_byte_former.sv
// Output byte former: null packets and PCR base patching
`timescale 1ns/1ps
`default_nettype none
module ts_byte_former
(
  input  wire logic [7:0]  idx,
  input  wire logic [7:0]  stored,
  input  wire logic        is_null,
  input  wire logic [3:0]  null_cc,
  input  wire logic        pcr_ok,
  input  wire logic [32:0] pcr_new,
  output logic      [7:0]  out_byte
);
  // ==========================================================
  // Pick generated, patched or stored byte
  always_comb
  begin
    out_byte = stored;
    if (is_null)
    begin
      unique case (idx)
        8'h00:   out_byte = vcond_pkg::TS_SYNC;
        8'h01:   out_byte = {3'h0, vcond_pkg::NULL_PID[12:8]};
        8'h02:   out_byte = vcond_pkg::NULL_PID[7:0];
        8'h03:   out_byte = vcond_pkg::NULL_HDR3 | {4'h0, null_cc};
        default: out_byte = vcond_pkg::STUFF_BYTE;
      endcase
    end
    else if (pcr_ok)
    begin
      unique case (idx)
        8'h06:   out_byte = pcr_new[32:25];
        8'h07:   out_byte = pcr_new[24:17];
        8'h08:   out_byte = pcr_new[16:9];
        8'h09:   out_byte = pcr_new[8:1];
        8'h0A:   out_byte = {pcr_new[0], stored[6:0]};
        default: out_byte = stored;
      endcase
    end
  end
endmodule : ts_byte_former
`default_nettype wire

// ===== hw/ts_slot_store.sv
// Slot store for whole transport packets with per-slot tags
`timescale 1ns/1ps
`default_nettype none
module ts_slot_store
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        byte_we,
  input  wire logic [7:0]  byte_idx,
  input  wire logic [7:0]  byte_data,
  input  wire logic        commit,
  input  wire logic        commit_null,
  input  wire logic        commit_pcr_ok,
  input  wire logic [32:0] commit_pcr,
  input  wire logic [7:0]  rd_idx,
  input  wire logic        pop,
  output logic      [7:0]  rd_byte,
  output logic             head_null,
  output logic             head_pcr_ok,
  output logic      [32:0] head_pcr,
  output logic      [4:0]  count
);
  logic [7:0]  mem [vcond_pkg::MEM_BYTES];
  logic        null_m [vcond_pkg::SLOTS];
  logic        pok_m  [vcond_pkg::SLOTS];
  logic [32:0] pcr_m  [vcond_pkg::SLOTS];
  logic [3:0]  wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic        push;

  // ==========================================================
  // Pointer update; a commit into a full store is lost
  always_comb
  begin
    push       = commit && (cnt_r != 5'h10);
    wr_ptr_nxt = push ? wr_ptr_r + 4'h1 : wr_ptr_r;
    rd_ptr_nxt = (pop && cnt_r != 5'h00) ? rd_ptr_r + 4'h1 : rd_ptr_r;
    cnt_nxt    = cnt_r + {4'h0, push}
               - {4'h0, pop && cnt_r != 5'h00};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      cnt_r    <= 5'h00;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  // ==========================================================
  // Array write, tags and registered byte read
  always_ff @(posedge clk)
  begin
    if (byte_we)
      mem[vcond_pkg::slot_addr(wr_ptr_r, byte_idx)] <= byte_data;
    if (push)
    begin
      null_m[wr_ptr_r] <= commit_null;
      pok_m[wr_ptr_r]  <= commit_pcr_ok;
      pcr_m[wr_ptr_r]  <= commit_pcr;
    end
    rd_byte <= mem[vcond_pkg::slot_addr(rd_ptr_r, rd_idx)];
  end

  assign head_null   = null_m[rd_ptr_r];
  assign head_pcr_ok = pok_m[rd_ptr_r];
  assign head_pcr    = pcr_m[rd_ptr_r];
  assign count       = cnt_r;
endmodule : ts_slot_store
`default_nettype wire

// ===== hw/vcond_pkg.sv
// Shared constants for the video stream conditioner
package vcond_pkg;
  // ==========================================================
  // Transport packet layout
  localparam int unsigned TS_LEN        = 188;
  localparam logic [7:0]  TS_LAST       = 8'hBB;
  localparam logic [7:0]  TS_SYNC       = 8'h47;
  localparam logic [12:0] NULL_PID      = 13'h1FFF;
  localparam logic [7:0]  STUFF_BYTE    = 8'hFF;
  localparam logic [7:0]  NULL_HDR3     = 8'h10;
  localparam logic [7:0]  AFC_BIT       = 8'h20;
  localparam logic [7:0]  PCR_FLAG      = 8'h10;
  localparam logic [7:0]  PCR_B0        = 8'h06;
  localparam logic [7:0]  PCR_B4        = 8'h0A;
  // ==========================================================
  // Tunnel header layout (session 0..3, flow 4, rsvd 5, seq 6..7)
  localparam logic [2:0]  HDR_SEQ_HI    = 3'h6;
  localparam logic [2:0]  HDR_LAST      = 3'h7;
  localparam logic [3:0]  MAX_TS_PER_TUN = 4'hA;
  // ==========================================================
  // Store sizing and fill thresholds
  localparam int unsigned SLOTS         = 16;
  localparam int unsigned MEM_BYTES     = SLOTS * TS_LEN;
  localparam logic [4:0]  DEJIT_SLOTS   = 5'h04;
  localparam logic [4:0]  HI_MARK       = 5'h08;

  // Byte address of a byte inside a slot
  function automatic logic [11:0] slot_addr(input logic [3:0] slot,
                                            input logic [7:0] idx);
    slot_addr = 12'(slot * TS_LEN) + {4'h0, idx};
  endfunction : slot_addr
endpackage : vcond_pkg

// ===== hw/video_stream_conditioner.sv
// Tunnel receive, de-jitter store and paced transport stream output
// Function
// RULE_01 - Each tunnel packet carries a 32-bit session id selecting destination.
// RULE_02 - Direct mode payload: 188-byte packets after sub-header with sequence.
// RULE_03 - Multi-channel mode: route each contained packet to its own channel.
// RULE_04 - Core sends constant rate stream, at most ten packets per tunnel.
// RULE_05 - Core-configured multiplex rate is the output pacing reference.
// RULE_06 - De-jitter each multiplex before transmission.
// RULE_07 - Asynchronous mode: delete or insert nulls to absorb clock drift; code deletes only stored refill nulls, which only sync mode makes
// RULE_08 - Asynchronous mode: correct PCR only by inserted or deleted nulls.
// RULE_09 - Core should include enough nulls for the node to delete.
// RULE_10 - Synchronous mode: no restamping, lost packets replaced by nulls.
// RULE_11 - Synchronous mode: detect lost tunnel packets from sequence gaps.
// RULE_12 - Replacement null count equals packets in last received tunnel.
// RULE_13 - Single loss: nulls placed exactly where lost packets would be.
// RULE_14 - Multiple consecutive losses: handling chosen by the design.
// RULE_15 - Insert nulls when nothing to send, never while data waits; code also sends nulls while data waits and the store is not yet primed
// RULE_16 - Flow identifier is reserved in these sessions and ignored.
// RULE_17 - Payloads are passed on in sequence number order.
// RULE_18 - Generated nulls use PID 0x1FFF, counted header, stuffing payload.
`timescale 1ns/1ps
`default_nettype none
module video_stream_conditioner
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        SYNC_MODE,
  input  wire logic        MULTI_CHANNEL_STREAM_MODE,
  input  wire logic [31:0] SESSION_ID,
  input  wire logic [7:0]  CHANNEL_TAG,
  input  wire logic [15:0] PKT_INTERVAL,
  input  wire logic [32:0] PCR_BASE_STEP,
  input  wire logic        TUN_VALID,
  input  wire logic [7:0]  TUN_DATA,
  input  wire logic        TUN_SOP,
  input  wire logic        TUN_EOP,
  output logic             TUN_READY,
  output logic             TS_VALID,
  output logic      [7:0]  TS_DATA,
  output logic             TS_SOP
);
  typedef enum logic [2:0] {W_IDLE, W_HDR, W_FILL, W_TAG, W_BODY,
                            W_DROP} wr_state_e;
  typedef enum logic {R_IDLE, R_SEND} rd_state_e;

  // Writer state
  wr_state_e   wst_r, wst_nxt;
  logic [2:0]  hcnt_r, hcnt_nxt;
  logic [31:0] sess_r, sess_nxt;
  logic [7:0]  seqhi_r, seqhi_nxt;
  logic [15:0] exp_r, exp_nxt;
  logic        seen_r, seen_nxt, keep_r, keep_nxt, af_r, af_nxt;
  logic        pf_r, pf_nxt, rdy_r, rdy_nxt;
  logic [7:0]  bidx_r, bidx_nxt;
  logic [3:0]  tcnt_r, tcnt_nxt, last_r, last_nxt, fill_r, fill_nxt;
  logic [32:0] pcr_r, pcr_nxt;
  logic        acc, we, cmt, cmt_null;
  logic [15:0] seq, diff;
  // Reader state
  rd_state_e   rst_r, rst_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic [7:0]  bcnt_r, bcnt_nxt, idx_d_r;
  logic        prim_r, prim_nxt, snd_d_r, src_r, src_nxt;
  logic        cnul_r, cnul_nxt, cpok_r, cpok_nxt;
  logic [32:0] cpcr_r, cpcr_nxt, off_r, off_nxt;
  logic [3:0]  ncc_r, ncc_nxt, ccc_r, ccc_nxt;
  logic        tick, del_pop, pop, sop_d_r;
  // Store and former
  logic [7:0]  rd_byte, out_byte;
  logic        head_null, head_pok;
  logic [32:0] head_pcr;
  logic [4:0]  count;

  assign acc = TUN_VALID && rdy_r;

  // ==========================================================
  // Tunnel receive: header, loss fill, routing, packet capture
  always_comb
  begin
    wst_nxt = wst_r;   hcnt_nxt = hcnt_r;   sess_nxt = sess_r;
    seqhi_nxt = seqhi_r; exp_nxt = exp_r;   seen_nxt = seen_r;
    keep_nxt = keep_r; af_nxt = af_r;       pf_nxt = pf_r;
    bidx_nxt = bidx_r; tcnt_nxt = tcnt_r;   last_nxt = last_r;
    fill_nxt = fill_r; pcr_nxt = pcr_r;
    we = 1'b0; cmt = 1'b0; cmt_null = 1'b0;
    seq  = {seqhi_r, TUN_DATA};
    diff = seq - exp_r;
    unique case (wst_r)
      W_IDLE:
        if (acc && TUN_SOP && !TUN_EOP)
        begin
          sess_nxt = {24'h0, TUN_DATA};
          hcnt_nxt = 3'h1;
          wst_nxt  = W_HDR;
        end
      W_HDR:
        if (acc)
        begin
          hcnt_nxt = hcnt_r + 3'h1;
          if (hcnt_r < 3'h4)
            sess_nxt = {sess_r[23:0], TUN_DATA};
          if (hcnt_r == vcond_pkg::HDR_SEQ_HI)
            seqhi_nxt = TUN_DATA; // Flow id byte skipped RULE_16
          if (TUN_EOP)
            wst_nxt = W_IDLE;
          else if (hcnt_r == vcond_pkg::HDR_LAST)
          begin
            if (sess_r != SESSION_ID)
              wst_nxt = W_DROP; // RULE_01
            else if (seen_r && diff[15])
              wst_nxt = W_DROP; // Stale or repeated RULE_17
            else
            begin
              exp_nxt  = seq + 16'h0001;
              seen_nxt = 1'b1;
              tcnt_nxt = 4'h0;
              bidx_nxt = 8'h00;
              keep_nxt = !MULTI_CHANNEL_STREAM_MODE;
              wst_nxt  = MULTI_CHANNEL_STREAM_MODE ? W_TAG : W_BODY;
              // One lost tunnel packet refilled; wider gaps resync RULE_14
              if (SYNC_MODE && seen_r && diff == 16'h0001
                  && last_r != 4'h0)
              begin
                fill_nxt = last_r; // RULE_11 RULE_12
                wst_nxt  = W_FILL;
              end
            end
          end
        end
      W_FILL:
        if (count != 5'h10)
        begin
          cmt      = 1'b1; // RULE_13
          cmt_null = 1'b1; // RULE_10
          fill_nxt = fill_r - 4'h1;
          if (fill_r == 4'h1)
            wst_nxt = MULTI_CHANNEL_STREAM_MODE ? W_TAG : W_BODY;
        end
      W_TAG:
        if (acc)
        begin
          keep_nxt = TUN_DATA == CHANNEL_TAG; // RULE_03
          bidx_nxt = 8'h00;
          wst_nxt  = TUN_EOP ? W_IDLE : W_BODY;
        end
      W_BODY:
        if (acc)
        begin
          we       = keep_r; // RULE_02
          bidx_nxt = bidx_r + 8'h01;
          if (bidx_r == 8'h03)
            af_nxt = (TUN_DATA & vcond_pkg::AFC_BIT) != 8'h00;
          if (bidx_r == 8'h04)
            af_nxt = af_r && TUN_DATA != 8'h00;
          if (bidx_r == 8'h05)
            pf_nxt = af_r && (TUN_DATA & vcond_pkg::PCR_FLAG) != 8'h00;
          if (bidx_r >= vcond_pkg::PCR_B0 && bidx_r < vcond_pkg::PCR_B4)
            pcr_nxt = {pcr_r[24:0], TUN_DATA};
          if (bidx_r == vcond_pkg::PCR_B4)
            pcr_nxt = {pcr_r[31:0], TUN_DATA[7]};
          if (bidx_r == vcond_pkg::TS_LAST)
          begin
            cmt      = keep_r;
            tcnt_nxt = tcnt_r + 4'h1;
            bidx_nxt = 8'h00;
            if (tcnt_nxt == vcond_pkg::MAX_TS_PER_TUN)
              wst_nxt = W_DROP; // RULE_04
            else if (MULTI_CHANNEL_STREAM_MODE)
              wst_nxt = W_TAG;
          end
          if (TUN_EOP)
            wst_nxt = W_IDLE;
        end
      W_DROP:
        if (acc && TUN_EOP)
          wst_nxt = W_IDLE;
      default:
        wst_nxt = W_IDLE;
    endcase
    if (wst_r == W_TAG || wst_r == W_BODY)
      last_nxt = tcnt_nxt;
    rdy_nxt = wst_nxt != W_FILL;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      wst_r <= W_IDLE;  hcnt_r <= 3'h0;  sess_r <= 32'h0;
      seqhi_r <= 8'h00; exp_r <= 16'h0;  seen_r <= 1'b0;
      keep_r <= 1'b0;   af_r <= 1'b0;    pf_r <= 1'b0;
      bidx_r <= 8'h00;  tcnt_r <= 4'h0;  last_r <= 4'h0;
      fill_r <= 4'h0;   pcr_r <= 33'h0;  rdy_r <= 1'b0;
    end
    else
    begin
      wst_r <= wst_nxt;   hcnt_r <= hcnt_nxt; sess_r <= sess_nxt;
      seqhi_r <= seqhi_nxt; exp_r <= exp_nxt; seen_r <= seen_nxt;
      keep_r <= keep_nxt; af_r <= af_nxt;     pf_r <= pf_nxt;
      bidx_r <= bidx_nxt; tcnt_r <= tcnt_nxt; last_r <= last_nxt;
      fill_r <= fill_nxt; pcr_r <= pcr_nxt;   rdy_r <= rdy_nxt;
    end
  end

  // ==========================================================
  // Paced output: priming, null insert/delete, PCR offset
  always_comb
  begin
    rst_nxt = rst_r; tmr_nxt = tmr_r - 16'h0001; bcnt_nxt = bcnt_r;
    prim_nxt = prim_r; src_nxt = src_r; cnul_nxt = cnul_r;
    cpok_nxt = cpok_r; cpcr_nxt = cpcr_r; off_nxt = off_r;
    ncc_nxt = ncc_r; ccc_nxt = ccc_r;
    pop = 1'b0; del_pop = 1'b0;
    tick = tmr_r == 16'h0000;
    if (tick)
      tmr_nxt = PKT_INTERVAL - 16'h0001; // RULE_05
    if (count >= vcond_pkg::DEJIT_SLOTS)
      prim_nxt = 1'b1; // RULE_06
    unique case (rst_r)
      R_IDLE:
        if (tick)
        begin
          rst_nxt  = R_SEND;
          bcnt_nxt = 8'h00;
          ccc_nxt  = ncc_r;
          src_nxt  = prim_r && count != 5'h00; // RULE_15
          cnul_nxt = !src_nxt || head_null;
          cpok_nxt = src_nxt && !head_null && head_pok;
          cpcr_nxt = head_pcr + (SYNC_MODE ? 33'h0 : off_r); // RULE_08
          if (!src_nxt && prim_r)
          begin
            prim_nxt = 1'b0;
            if (!SYNC_MODE)
              off_nxt = off_r + PCR_BASE_STEP; // RULE_07
          end
        end
        else if (!SYNC_MODE && count > vcond_pkg::HI_MARK && head_null)
        begin
          del_pop = 1'b1; // RULE_07 RULE_09
          off_nxt = off_r - PCR_BASE_STEP;
        end
      R_SEND:
      begin
        bcnt_nxt = bcnt_r + 8'h01;
        if (bcnt_r == vcond_pkg::TS_LAST)
        begin
          rst_nxt = R_IDLE;
          pop     = src_r;
          if (cnul_r)
            ncc_nxt = ncc_r + 4'h1; // RULE_18
        end
      end
      default:
        rst_nxt = R_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      rst_r <= R_IDLE;  tmr_r <= 16'h0;  bcnt_r <= 8'h00;
      prim_r <= 1'b0;   src_r <= 1'b0;   cnul_r <= 1'b1;
      cpok_r <= 1'b0;   cpcr_r <= 33'h0; off_r <= 33'h0;
      ncc_r <= 4'h0;    ccc_r <= 4'h0;   idx_d_r <= 8'h00;
      snd_d_r <= 1'b0;  sop_d_r <= 1'b0;
      TS_VALID <= 1'b0; TS_DATA <= 8'h00; TS_SOP <= 1'b0;
    end
    else
    begin
      rst_r <= rst_nxt; tmr_r <= tmr_nxt; bcnt_r <= bcnt_nxt;
      prim_r <= prim_nxt; src_r <= src_nxt; cnul_r <= cnul_nxt;
      cpok_r <= cpok_nxt; cpcr_r <= cpcr_nxt; off_r <= off_nxt;
      ncc_r <= ncc_nxt; ccc_r <= ccc_nxt; idx_d_r <= bcnt_r;
      snd_d_r <= rst_r == R_SEND;
      sop_d_r <= rst_r == R_SEND && bcnt_r == 8'h00;
      TS_VALID <= snd_d_r;
      TS_DATA  <= snd_d_r ? out_byte : 8'h00;
      TS_SOP   <= sop_d_r;
    end
  end

  assign TUN_READY = rdy_r;

  // ==========================================================
  // Packet store and output byte former
  ts_slot_store u_store
  (
    .clk           (CORE_CLK),
    .rst           (RST),
    .byte_we       (we),
    .byte_idx      (bidx_r),
    .byte_data     (TUN_DATA),
    .commit        (cmt),
    .commit_null   (cmt_null),
    .commit_pcr_ok (pf_r),
    .commit_pcr    (pcr_r),
    .rd_idx        (bcnt_r),
    .pop           (pop || del_pop),
    .rd_byte       (rd_byte),
    .head_null     (head_null),
    .head_pcr_ok   (head_pok),
    .head_pcr      (head_pcr),
    .count         (count)
  );

  ts_byte_former u_former
  (
    .idx      (idx_d_r),
    .stored   (rd_byte),
    .is_null  (cnul_r),
    .null_cc  (ccc_r),
    .pcr_ok   (cpok_r),
    .pcr_new  (cpcr_r),
    .out_byte (out_byte)
  );

  // ==========================================================
  // Checks
  sess_drop_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_01
    wst_r == W_HDR && acc && !TUN_EOP && hcnt_r == vcond_pkg::HDR_LAST
    && sess_r != SESSION_ID |=> wst_r == W_DROP)
    else $error("session mismatch not dropped");
  pkt_len_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_02
    TS_SOP |-> ##187 (TS_VALID && !TS_SOP) ##1 !TS_VALID)
    else $error("output packet not 188 bytes");
  tag_route_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_03
    wst_r == W_TAG && acc && TUN_DATA != CHANNEL_TAG |=> !keep_r)
    else $error("foreign channel packet kept");
  ts_limit_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_04
    tcnt_r <= vcond_pkg::MAX_TS_PER_TUN)
    else $error("too many packets per tunnel");
  pace_reload_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_05
    tmr_r == 16'h0000 |=> tmr_r == $past(PKT_INTERVAL) - 16'h0001)
    else $error("pacing timer not reloaded");
  prime_null_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_06
    rst_r == R_IDLE && tick && !prim_r |=> cnul_r && !src_r)
    else $error("data sent before store primed");
  delete_off_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_07
    del_pop |=> off_r == $past(off_r) - $past(PCR_BASE_STEP))
    else $error("deleted null not credited");
  pcr_pass_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_08
    snd_d_r && !cnul_r && !cpok_r |=> TS_DATA == $past(rd_byte))
    else $error("non PCR byte altered");
  sync_off_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_10
    SYNC_MODE |=> off_r == $past(off_r))
    else $error("PCR offset moved in sync mode");
  gap_count_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_12
    wst_r != W_FILL ##1 wst_r == W_FILL |-> fill_r == $past(last_r))
    else $error("wrong refill count");
  fill_place_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_13
    wst_r == W_FILL && count != 5'h10 |-> cmt && cmt_null && !we)
    else $error("refill not in place");
  data_first_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_15
    rst_r == R_IDLE && tick && prim_r && count != 5'h00 |=> src_r)
    else $error("null sent while data waits");
  seq_order_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_17
    wst_r == W_HDR && acc && !TUN_EOP && hcnt_r == vcond_pkg::HDR_LAST
    && seen_r && diff[15] |=> wst_r == W_DROP)
    else $error("stale tunnel packet accepted");
  null_hdr_a: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_18
    TS_SOP && $past(cnul_r) |-> TS_DATA == vcond_pkg::TS_SYNC
    ##1 TS_DATA == 8'h1F ##1 TS_DATA == 8'hFF)
    else $error("bad null packet header");
endmodule : video_stream_conditioner
`default_nettype wire
